// file: rtl/charger_regs.svh
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH
// register byte offsets
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define REPORT_OFFSET 12'h008
// control fields
`define CTRL_EN_BIT 0
`define CTRL_USBSEL_BIT 1
`define CTRL_RESET_VALUE 32'h0000_0001
// bus encodings
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'b0
// current level divisors and termination per mille
`define TRICKLE_DIV_FAST 10
`define TRICKLE_DIV_USB_LOW_LEVEL 2
`define TERM_PERMILLE_FAST 10'h04b
`define TERM_PERMILLE_USB_LOW_LEVEL 10'h15e
// serial status timing
`define REQ_PULSE_NS 200
`define DATA_FREQ_KHZ 20
`define CLK_MHZ 200
`define STATE_COUNT 22
`endif

// file: rtl/charger_pkg.sv
`default_nettype none
package charger_pkg;
  typedef enum logic [1:0] {src_none_type_v, src_adapter, src_usb_high,
    src_usb_low} source_type;
  typedef enum logic [2:0] {ph_check, ph_precond, ph_fast, ph_cvolt,
    ph_standby, ph_sleep, ph_fault} phase_type;
  typedef struct packed {
    logic adapter_present;
    logic usb_present;
    logic above_uvlo;
    logic therm_ok;
    logic cell_present;
    logic above_min;
    logic at_regulation;
    logic below_recharge;
    logic below_term;
    logic overvoltage;
    logic overtemp;
  } sense_type;
  typedef struct packed {
    source_type source;
    logic [1:0] level;
    logic trickle;
    logic enable;
  } drive_type;
endpackage
`default_nettype wire

// file: rtl/status_serializer.sv
`timescale 1ns/1ps
`default_nettype none
`include "charger_regs.svh"
module status_serializer #(
  parameter int unsigned BIT_CYCLES = 10000,
  parameter int unsigned REQ_CYCLES = 40
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request line (already synchronised) and code
  input wire logic req_low,
  input wire logic [4:0] code,
  // open-drain data
  output logic data_oe,
  output logic busy
);
  typedef enum logic [1:0] {s_idle, s_wait, s_send} ser_state_type;
  ser_state_type state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  logic [4:0] shift_reg, shift_next;
  logic oe_reg, oe_next;
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    oe_next = 1'b0;
    case (state_reg)
      s_idle:
      begin
        // request pulse must last the minimum width
        if (req_low)
        begin
          cnt_next = cnt_reg + 16'h0001;
        end
        else
        begin
          if (cnt_reg >= 16'(REQ_CYCLES))
          begin
            state_next = s_send; // [R18]
            shift_next = code;
            bit_next = 3'h0;
          end
          cnt_next = 16'h0000;
        end
      end
      s_send:
      begin
        // one bit per period at the data rate, low means one
        oe_next = shift_reg[0]; // [R16]
        if (cnt_reg == 16'(BIT_CYCLES - 1))
        begin
          cnt_next = 16'h0000;
          shift_next = {1'b0, shift_reg[4:1]};
          if (bit_reg == 3'h4)
          begin
            state_next = s_wait;
            oe_next = 1'b0;
          end
          bit_next = bit_reg + 3'h1;
        end
        else
        begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      s_wait:
      begin
        if (!req_low)
        begin
          state_next = s_idle;
        end
      end
      default:
      begin
        state_next = s_idle;
      end
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= s_idle;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      shift_reg <= 5'h00;
      oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      oe_reg <= oe_next;
    end
  end
  assign data_oe = oe_reg;
  assign busy = (state_reg == s_send);
endmodule // status_serializer
`default_nettype wire

// file: rtl/li_ion_charge_sequencer.sv
// Summary of operation
// R1: adapter present disables usb charging
// R2: same phase cycle for every source
// R3: start needs supply, thermistor window, cell
// R4: below minimum voltage enters preconditioning
// R5: trickle is tenth, half in usb-low
// R6: above minimum voltage enters constant current
// R7: fast level follows active source mode
// R8: regulation voltage reached enters constant voltage
// R9: termination current ends charge into standby
// R10: standby until below recharge threshold
// R11: supply loss, lockout or disable sleeps
// R12: resume automatically after supply recovers
// R13: overvoltage or overtemperature shuts down
// R14: thermistor out of window shuts down
// R15: faults show on leds and serial
// R16: serial reports the full charger state set
// R17: two strong led outputs show status
// R18: request pulse width, data at rate
// R19: comparators registered, reset to check
`timescale 1ns/1ps
`default_nettype none
`include "charger_regs.svh"
module li_ion_charge_sequencer #(
  parameter int unsigned CLK_MHZ = `CLK_MHZ
)
(
  // bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // comparator results
  input wire logic adapter_input,
  input wire logic usb_in,
  input wire logic uvlo_ok,
  input wire logic battery_thermistor_in,
  input wire logic cell_terminal,
  input wire logic above_min,
  input wire logic at_regulation,
  input wire logic below_recharge,
  input wire logic below_term,
  input wire logic overvoltage,
  input wire logic overtemp,
  // enable pin and serial status line
  input wire logic enable_pin,
  input wire logic data_in,
  output logic data_oe,
  // current selection
  output logic [1:0] fast_current_level,
  output logic trickle_sel,
  output logic [9:0] term_permille,
  output logic charge_on,
  output logic usb_charge_off,
  // indicators
  output logic led1_on,
  output logic led2_on
);
  localparam int unsigned REQ_CYC =
    (`REQ_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BIT_CYC = (CLK_MHZ * 1000) / `DATA_FREQ_KHZ;

  // two-flop synchronisers for all comparator pins
  // the data line is inverted so a request reads as one
  localparam int NIN = 13;
  logic [NIN-1:0] raw, s1_reg, s2_reg;
  charger_pkg::sense_type sense;
  logic en_s, req_low;
  assign raw = {adapter_input, usb_in, uvlo_ok, battery_thermistor_in,
    cell_terminal, above_min, at_regulation, below_recharge, below_term,
    overvoltage, overtemp, enable_pin, ~data_in};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
    end
    else
    begin
      s1_reg <= raw; // [R19]
      s2_reg <= s1_reg; // [R19]
    end
  end
  assign sense = charger_pkg::sense_type'(s2_reg[NIN-1:2]);
  assign en_s = s2_reg[1];
  assign req_low = s2_reg[0];

  // registers
  logic [31:0] ctrl_reg, ctrl_next;
  logic ap_valid_reg, ap_valid_next;
  logic ap_write_reg, ap_write_next;
  logic [11:0] ap_addr_reg, ap_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [4:0] code_reg, code_next;
  // only whole-word writes land
  logic ap_word_reg, ap_word_next;
  // ready and response held in flops so every output is registered
  logic ready_reg, resp_reg;
  logic ser_busy;

  // phase machine
  charger_pkg::phase_type phase_reg, phase_next;
  charger_pkg::source_type src;
  logic sw_en, fault_now, supply_ok, start_ok;
  assign sw_en = ctrl_reg[`CTRL_EN_BIT] & en_s;
  always_comb
  begin
    // adapter always wins over usb
    if (sense.adapter_present)
    begin
      src = charger_pkg::src_adapter; // [R1]
    end
    else if (sense.usb_present)
    begin
      src = ctrl_reg[`CTRL_USBSEL_BIT] ? charger_pkg::src_usb_high
        : charger_pkg::src_usb_low;
    end
    else
    begin
      src = charger_pkg::src_none_type_v;
    end
  end
  assign supply_ok = (src != charger_pkg::src_none_type_v) &&
    sense.above_uvlo;
  assign start_ok = supply_ok && sense.therm_ok && sense.cell_present;
  assign fault_now = sense.overvoltage || sense.overtemp; // [R13]

  always_comb
  begin
    phase_next = phase_reg;
    if (!supply_ok || !sw_en)
    begin
      phase_next = charger_pkg::ph_sleep; // [R11]
    end
    else if (fault_now)
    begin
      phase_next = charger_pkg::ph_fault; // [R13]
    end
    else
    begin
      case (phase_reg)
        charger_pkg::ph_check:
        begin
          if (start_ok) // [R3]
          begin
            phase_next = sense.above_min ? charger_pkg::ph_fast
              : charger_pkg::ph_precond; // [R4] [R2]
          end
        end
        charger_pkg::ph_precond:
        begin
          if (!sense.therm_ok)
          begin
            phase_next = charger_pkg::ph_fault; // [R14]
          end
          else if (sense.above_min)
          begin
            phase_next = charger_pkg::ph_fast; // [R6]
          end
        end
        charger_pkg::ph_fast:
        begin
          if (!sense.therm_ok)
          begin
            phase_next = charger_pkg::ph_fault; // [R14]
          end
          else if (sense.at_regulation)
          begin
            phase_next = charger_pkg::ph_cvolt; // [R8]
          end
        end
        charger_pkg::ph_cvolt:
        begin
          if (!sense.therm_ok)
          begin
            phase_next = charger_pkg::ph_fault; // [R14]
          end
          else if (sense.below_term)
          begin
            phase_next = charger_pkg::ph_standby; // [R9]
          end
        end
        charger_pkg::ph_standby:
        begin
          if (sense.below_recharge)
          begin
            phase_next = charger_pkg::ph_check; // [R10]
          end
        end
        charger_pkg::ph_sleep:
        begin
          phase_next = charger_pkg::ph_check; // [R12]
        end
        // a fault holds until a sleep clears it
        charger_pkg::ph_fault:
        begin
          phase_next = charger_pkg::ph_fault;
        end
        default:
        begin
          phase_next = charger_pkg::ph_check;
        end
      endcase
    end
  end

  // outputs from the phase and the source, all registered
  logic [1:0] lvl_next;
  logic trk_next, on_next, usboff_next, l1_next, l2_next;
  logic [9:0] term_next;
  always_comb
  begin
    lvl_next = 2'(src); // [R7]
    trk_next = (phase_next == charger_pkg::ph_precond); // [R5]
    on_next = (phase_next == charger_pkg::ph_precond) ||
      (phase_next == charger_pkg::ph_fast) ||
      (phase_next == charger_pkg::ph_cvolt);
    usboff_next = sense.adapter_present; // [R1]
    term_next = (src == charger_pkg::src_usb_low) ? `TERM_PERMILLE_USB_LOW_LEVEL
      : `TERM_PERMILLE_FAST; // [R9]
    // led1 charging, led2 done, both on for fault
    l1_next = on_next || (phase_next == charger_pkg::ph_fault); // [R17]
    l2_next = (phase_next == charger_pkg::ph_standby) ||
      (phase_next == charger_pkg::ph_fault); // [R15]
    code_next = {2'(src), 3'(phase_next)}; // [R15] [R16]
  end
  logic [1:0] lvl_reg;
  logic trk_reg, on_reg, usboff_reg, l1_reg, l2_reg;
  logic [9:0] term_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_reg <= charger_pkg::ph_check; // [R19]
      lvl_reg <= 2'h0;
      trk_reg <= 1'b0;
      on_reg <= 1'b0;
      usboff_reg <= 1'b0;
      l1_reg <= 1'b0;
      l2_reg <= 1'b0;
      term_reg <= 10'h000;
      code_reg <= 5'h00;
    end
    else
    begin
      phase_reg <= phase_next;
      lvl_reg <= lvl_next;
      trk_reg <= trk_next;
      on_reg <= on_next;
      usboff_reg <= usboff_next;
      l1_reg <= l1_next;
      l2_reg <= l2_next;
      term_reg <= term_next;
      code_reg <= code_next;
    end
  end
  assign fast_current_level = lvl_reg;
  assign trickle_sel = trk_reg;
  assign charge_on = on_reg;
  assign usb_charge_off = usboff_reg;
  assign led1_on = l1_reg;
  assign led2_on = l2_reg;
  assign term_permille = term_reg;

  status_serializer #(
    .BIT_CYCLES(BIT_CYC),
    .REQ_CYCLES(REQ_CYC)
  ) u_ser (
    .hclk(hclk),
    .hresetn(hresetn),
    .req_low(req_low),
    .code(code_reg),
    .data_oe(data_oe),
    .busy(ser_busy)
  ); // [R18]

  // ahb-lite slave, zero wait states
  always_comb
  begin
    ap_valid_next = hsel && hready && htrans[1];
    ap_write_next = hwrite;
    ap_addr_next = haddr;
    // read data launches in the address phase, writes land a cycle later
    ap_word_next = (hsize == `HSIZE_WORD);
    ctrl_next = ctrl_reg;
    rdata_next = 32'h0000_0000;
    if (ap_valid_reg && ap_write_reg && ap_word_reg &&
      ap_addr_reg == `CTRL_OFFSET)
    begin
      ctrl_next = {30'h0000_0000, hwdata[1:0]};
    end
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr)
        `CTRL_OFFSET: rdata_next = ctrl_reg;
        `STATUS_OFFSET: rdata_next = {25'h000_0000, ser_busy, on_reg,
          l2_reg, l1_reg, trk_reg, lvl_reg};
        `REPORT_OFFSET: rdata_next = {19'h0_0000, 5'(s2_reg[NIN-1:2]),
          3'h0, code_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 12'h000;
      ap_word_reg <= 1'b0;
      ready_reg <= 1'b1;
      resp_reg <= `HRESP_OKAY;
      ctrl_reg <= `CTRL_RESET_VALUE;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ap_valid_reg <= ap_valid_next;
      ap_write_reg <= ap_write_next;
      ap_addr_reg <= ap_addr_next;
      ap_word_reg <= ap_word_next;
      ready_reg <= 1'b1;
      resp_reg <= `HRESP_OKAY;
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end
  assign hrdata = rdata_reg;
  assign hreadyout = ready_reg;
  assign hresp = resp_reg;
endmodule // li_ion_charge_sequencer
`default_nettype wire

// file: testbench/charger_checker.sv
`timescale 1ns/1ps
`default_nettype none
module charger_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // comparator and enable inputs
  input wire logic adapter_input,
  input wire logic uvlo_ok,
  input wire logic battery_thermistor_in,
  input wire logic cell_terminal,
  input wire logic overvoltage,
  input wire logic overtemp,
  input wire logic enable_pin,
  // selection and indicator outputs
  input wire logic [1:0] fast_current_level,
  input wire logic [9:0] term_permille,
  input wire logic charge_on,
  input wire logic usb_charge_off,
  input wire logic led1_on,
  input wire logic led2_on
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_USB_OFF: assert property (
    adapter_input [*6] |-> usb_charge_off) else $error("usb not off");
  AST_ADP_LEVEL: assert property (
    adapter_input [*6] ##0 charge_on |-> fast_current_level == 2'h1)
    else $error("adapter level wrong");
  AST_CELL: assert property (
    !cell_terminal [*6] ##0 !charge_on |=> !charge_on)
    else $error("charging with no cell");
  AST_OVERVOLT: assert property (
    overvoltage [*6] |-> !charge_on) else $error("overvoltage not shut");
  AST_OVERTEMP: assert property (
    overtemp [*6] |-> !charge_on && led1_on == led2_on)
    else $error("overtemp not shut");
  AST_THERM: assert property (
    !battery_thermistor_in [*6] |-> !charge_on)
    else $error("hot cell charged");
  AST_SLEEP: assert property (
    (!enable_pin || !uvlo_ok) [*6] |-> !charge_on && !led1_on && !led2_on)
    else $error("not asleep");
  AST_TERM_USB_LOW_LEVEL: assert property (
    (fast_current_level == 2'h3) [*3] |-> term_permille == 10'h15e)
    else $error("usb-low termination wrong");
  AST_CHARGE_LED: assert property (
    charge_on [*3] |-> led1_on && !led2_on) else $error("charge leds wrong");
endmodule // charger_checker
bind li_ion_charge_sequencer charger_checker checker_i (
  .hclk(hclk), .hresetn(hresetn), .adapter_input(adapter_input),
  .uvlo_ok(uvlo_ok), .battery_thermistor_in(battery_thermistor_in),
  .cell_terminal(cell_terminal), .overvoltage(overvoltage),
  .overtemp(overtemp), .enable_pin(enable_pin),
  .fast_current_level(fast_current_level), .term_permille(term_permille),
  .charge_on(charge_on), .usb_charge_off(usb_charge_off),
  .led1_on(led1_on), .led2_on(led2_on));
`default_nettype wire

// file: testbench/status_reader.sv
`timescale 1ns/1ps
`default_nettype none
module status_reader #(
  parameter int unsigned BIT = 100
)
(
  // clock
  input wire logic hclk,
  // open-drain status line
  input wire logic data_oe,
  output logic data_in
);
  logic pull_low = 1'b0;
  // pull-up: line high unless a party sinks it
  assign data_in = !(pull_low || data_oe);
  // request pulse, then sample each bit mid-period, lsb first
  task automatic fetch(output logic [4:0] got);
    @(posedge hclk);
    pull_low <= 1'b1;
    repeat (4) @(posedge hclk);
    pull_low <= 1'b0;
    repeat (3 + BIT / 2) @(posedge hclk);
    for (int i = 0; i < 5; i++)
    begin
      got[i] = !data_in;
      repeat (BIT) @(posedge hclk);
    end
  endtask
endmodule // status_reader
`default_nettype wire

// file: testbench/tb_li_ion_charge_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_li_ion_charge_sequencer;
  localparam int SHORT_MHZ = 2;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, data_in, data_oe, trickle_sel, charge_on;
  logic usb_charge_off, led1_on, led2_on;
  logic [1:0] level;
  logic [9:0] term_permille;
  logic [4:0] code;
  logic enable_pin = 1'b1;
  charger_pkg::sense_type s = '0;
  int n_mismatch = 0;
  int checks_done = 0;
  // charge flow: sense word, expected phase, expected charge_on
  logic [10:0] sv [17] = '{11'h7e0, 11'h7f0, 11'h7f4, 11'h7e0, 11'h7e8,
    11'h6e0, 11'h7e0, 11'h7e1, 11'h7e0, 11'h6e0, 11'h7e0, 11'h7e2,
    11'h6e0, 11'h7e0, 11'h760, 11'h6e0, 11'h7a0};
  logic [2:0] ph [17] = '{2, 3, 4, 4, 2, 5, 2, 6, 6, 5, 2, 6, 5, 2, 6, 5, 0};
  logic on [17] = '{1, 1, 0, 0, 1, 0, 1, 0, 0, 0, 1, 0, 0, 1, 0, 0, 0};
  always #2.5 hclk = ~hclk;
  li_ion_charge_sequencer #(.CLK_MHZ(SHORT_MHZ)) li_ion_charge_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .adapter_input(s.adapter_present), .usb_in(s.usb_present),
    .uvlo_ok(s.above_uvlo), .battery_thermistor_in(s.therm_ok),
    .cell_terminal(s.cell_present), .above_min(s.above_min),
    .at_regulation(s.at_regulation), .below_recharge(s.below_recharge),
    .below_term(s.below_term), .overvoltage(s.overvoltage),
    .overtemp(s.overtemp), .enable_pin(enable_pin), .data_in(data_in),
    .data_oe(data_oe), .fast_current_level(level), .trickle_sel(trickle_sel),
    .term_permille(term_permille), .charge_on(charge_on),
    .usb_charge_off(usb_charge_off), .led1_on(led1_on), .led2_on(led2_on));
  status_reader #(.BIT(SHORT_MHZ * 50)) status_reader_i (
    .hclk(hclk), .data_oe(data_oe), .data_in(data_in));
  task automatic check(input string name, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic put(input logic [10:0] v);
    @(posedge hclk);
    s <= charger_pkg::sense_type'(v);
    repeat (8) @(posedge hclk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 12'h000, 0);
    check("ctrl", rd, 32'h0000_0001);
    bus(0, 12'h004, 0);
    check("status", rd, 32'h0000_0000);
    bus(1, 12'h00c, 32'hffff_ffff);
    bus(0, 12'h00c, 0);
    check("unmapped", rd, 32'h0000_0000);
    check("hresp", 32'(hresp), 32'h0000_0000);
    put(11'h3c0);
    bus(0, 12'h004, 0);
    check("usb_low_level status", rd, 32'h0000_002f);
    check("usb_low_level term", 32'(term_permille), 32'h0000_015e);
    check("usb_low_level trickle", 32'(trickle_sel), 32'h0000_0001);
    bus(1, 12'h000, 32'h0000_0003);
    repeat (8) @(posedge hclk);
    bus(0, 12'h004, 0);
    check("usb_high_level status", rd, 32'h0000_002e);
    put(11'h7c0);
    bus(0, 12'h004, 0);
    check("adp status", rd, 32'h0000_002d);
    check("usb off", 32'(usb_charge_off), 32'h0000_0001);
    check("adp term", 32'(term_permille), 32'h0000_004b);
    for (int i = 0; i < 17; i++)
    begin
      put(sv[i]);
      bus(0, 12'h008, 0);
      check("phase", 32'(rd[2:0]), 32'(ph[i]));
      check("charge", 32'(charge_on), 32'(on[i]));
    end
    put(11'h7e0);
    enable_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    check("pin off", 32'(charge_on), 32'h0000_0000);
    enable_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    check("pin on", 32'(charge_on), 32'h0000_0001);
    bus(1, 12'h000, 32'h0000_0002);
    repeat (8) @(posedge hclk);
    check("soft off", 32'(charge_on), 32'h0000_0000);
    bus(1, 12'h000, 32'h0000_0003);
    put(11'h7f0);
    status_reader_i.fetch(code);
    check("serial cv", 32'(code), 32'h0000_000b);
    put(11'h7f1);
    check("fault leds", 32'({led1_on, led2_on}), 32'h0000_0003);
    status_reader_i.fetch(code);
    check("serial fault", 32'(code), 32'h0000_000e);
    give_verdict();
  end
endmodule // tb_li_ion_charge_sequencer
`default_nettype wire
